// ### rtl/prss_sequencer.sv
// Power, reset and sleep sequencer with its APB register file.
//
// The address map and the APB interface to the registers were left to the implementer.
module prss_sequencer import prss_pkg::*; #(
   parameter int NUM_BANKS = 8,
   parameter logic [31:0] WDOG_CYCLES = 32'd200000
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_irq,
   input wire logic i_gpio_wake,
   input wire logic i_xtal32k_tick,
   input wire logic i_rc10k_tick,
   input wire logic i_high_voltage_power_on_reset,
   input wire logic i_low_voltage_power_on_reset,
   input wire logic i_external_reset_pin_n,
   input wire logic i_option_byte_error,
   input wire logic i_debug_reset_req,
   input wire logic i_scan_port_test_reset,
   output logic o_cpu_halt,
   output logic o_aon_pwr_en,
   output logic o_core_pwr_en,
   output logic o_flash_pwr_en,
   output logic o_ram_retain_ldo_en,
   output logic [NUM_BANKS-1:0] o_ram_bank_pwr,
   output logic [NUM_BANKS-1:0] o_ram_bank_retain,
   output logic o_core_rst,
   output logic o_periph_rst,
   output logic o_dbg_rst,
   output logic o_sysclk_sel_xtal,
   output logic o_lf_clk_en,
   output logic o_irq
);
   prss_state_e state_q;
   prss_state_e state_d;
   prss_state_e mode_state_w;
   logic [31:0] prdata_q;
   logic [31:0] rd_w;
   logic hit_w;
   logic setup_w;
   logic wr_w;
   logic [NUM_BANKS-1:0] retain_q;
   logic [CAUSE_W-1:0] cause_q;
   logic [CAUSE_W-1:0] ev_w;
   logic any_ev_w;
   logic ext_ev_w;
   logic clksel_q;
   logic wd_en_q;
   logic [31:0] wd_cnt_q;
   logic wd_fire_w;
   logic wd_kick_w;
   logic [2:0] tcfg_q;
   logic [31:0] tcmp_q;
   logic [31:0] tcnt_w;
   logic tmatch_w;
   logic tmr_run_w;
   logic [IRQ_W-1:0] istat_q;
   logic [IRQ_W-1:0] imask_q;
   logic [IRQ_W-1:0] iset_w;
   logic [IRQ_W-1:0] iclr_w;
   logic [4:0] rst_cnt_q;
   logic full_q;
   logic sw_rst_w;
   logic sleep_go_w;
   logic mode_ok_w;
   logic true_ds_w;
   logic deep_w;
   logic clocks_off_w;
   logic wake_w;
   logic dsleep_ev_w;
   logic idle_exit_w;

   // APB decode; every access completes at once, so pready is a constant high.
   assign setup_w = i_psel && !i_penable;
   assign wr_w = i_psel && i_penable && i_pwrite;
   assign hit_w = (i_paddr[1:0] == 2'h0) && (i_paddr <= ADDR_SWRST);
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !hit_w;
   assign o_prdata = prdata_q;

   // Read mux; write-only and unmapped words read as zero.
   assign rd_w = (i_paddr == ADDR_SLEEP) ? {29'h0, state_q} :
                 (i_paddr == ADDR_RETAIN) ? 32'(retain_q) :
                 (i_paddr == ADDR_CAUSE) ? 32'(cause_q) :
                 (i_paddr == ADDR_CLKSEL) ? {31'h0, clksel_q} :
                 (i_paddr == ADDR_WDOG) ? {31'h0, wd_en_q} :
                 (i_paddr == ADDR_TCFG) ? {29'h0, tcfg_q} :
                 (i_paddr == ADDR_TCMP) ? tcmp_q :
                 (i_paddr == ADDR_TCNT) ? tcnt_w :
                 (i_paddr == ADDR_ISTAT) ? 32'(istat_q) :
                 (i_paddr == ADDR_IMASK) ? 32'(imask_q) : 32'h0;

   // Read data is captured in the setup cycle so that it is stable from a flop.
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         prdata_q <= 32'h0;
      end else if (setup_w) begin
         prdata_q <= rd_w;
      end
   end

   // Sleep requests are taken only while running and out of reset.
   assign mode_state_w = (i_pwdata[2:0] == MODE_IDLE) ? ST_IDLE :
                         (i_pwdata[2:0] == MODE_DS1) ? ST_DS1 :
                         (i_pwdata[2:0] == MODE_DS2) ? ST_DS2 : ST_DS0;
   assign mode_ok_w = (i_pwdata[2:0] >= MODE_IDLE) && (i_pwdata[2:0] <= MODE_DS0);
   assign sleep_go_w = wr_w && (i_paddr == ADDR_SLEEP) && mode_ok_w && (state_q == ST_RUN) && !o_core_rst;

   // Sleep mode qualifiers.
   assign true_ds_w = (state_q == ST_DS1) || (state_q == ST_DS2);
   assign deep_w = true_ds_w || (state_q == ST_DS0);
   assign clocks_off_w = deep_w && tcfg_q[TC_OFF_BIT];
   assign tmr_run_w = tcfg_q[TC_EN_BIT] && (state_q != ST_DS2) && !clocks_off_w;
   // A match pulse left over from the last running cycle must not wake a clocks-off sleep.
   assign wake_w = i_gpio_wake || (tmatch_w && state_q != ST_DS2 && !clocks_off_w);
   assign dsleep_ev_w = deep_w && wake_w;
   assign idle_exit_w = (state_q == ST_IDLE) && i_irq;

   // Reset sources, one flag per source.
   assign sw_rst_w = wr_w && (i_paddr == ADDR_SWRST) && (i_pwdata == SWRST_KEY);
   assign wd_fire_w = wd_en_q && (wd_cnt_q == WDOG_CYCLES - 32'h1);
   assign ev_w[CS_HIGH_VOLTAGE_POWER_ON_RESET] = i_high_voltage_power_on_reset;
   assign ev_w[CS_LOW_VOLTAGE_POWER_ON_RESET] = i_low_voltage_power_on_reset;
   assign ev_w[CS_PIN] = !i_external_reset_pin_n;
   assign ev_w[CS_WDOG] = wd_fire_w;
   assign ev_w[CS_SW] = sw_rst_w;
   assign ev_w[CS_OPT] = i_option_byte_error;
   assign ev_w[CS_DBG] = i_debug_reset_req;
   assign ev_w[CS_TEST] = i_scan_port_test_reset;
   assign ev_w[CS_DSLEEP] = dsleep_ev_w;
   assign ext_ev_w = |ev_w[CS_TEST:CS_HIGH_VOLTAGE_POWER_ON_RESET];
   assign any_ev_w = |ev_w;

   // Next power state; any reset event returns the device to run.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (sleep_go_w) begin
               state_d = mode_state_w;
            end
         end
         ST_IDLE: begin
            if (idle_exit_w) begin
               state_d = ST_RUN;
            end
         end
         ST_DS1, ST_DS2, ST_DS0: begin
            if (wake_w) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
      if (ext_ev_w) begin
         state_d = ST_RUN;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Reset hold counter and cause record; the record is rewritten on each event.
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rst_cnt_q <= RST_HOLD_CYCLES;
         full_q <= 1'b1;
         cause_q <= CAUSE_RST_VAL;
      end else if (any_ev_w) begin
         rst_cnt_q <= RST_HOLD_CYCLES;
         full_q <= |(ev_w & CAUSE_FULL_MASK);
         cause_q <= ev_w;
      end else if (rst_cnt_q != 5'h0) begin
         rst_cnt_q <= rst_cnt_q - 5'h1;
      end
   end

   // Core domain state is lost on every core reset, so the clock falls back to RC.
   assign wd_kick_w = wr_w && (i_paddr == ADDR_WDOG) && i_pwdata[WD_KICK_BIT];
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || o_core_rst) begin
         clksel_q <= 1'b0;
         wd_en_q <= 1'b0;
      end else if (wr_w) begin
         if (i_paddr == ADDR_CLKSEL) begin
            clksel_q <= i_pwdata[0];
         end
         if (i_paddr == ADDR_WDOG) begin
            wd_en_q <= wd_en_q || i_pwdata[WD_EN_BIT];
         end
      end
   end

   // Watchdog counter; it only counts while enabled and out of sleep.
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || !wd_en_q || wd_kick_w || wd_fire_w || state_q != ST_RUN) begin
         wd_cnt_q <= 32'h0;
      end else begin
         wd_cnt_q <= wd_cnt_q + 32'h1;
      end
   end

   // Always-on configuration kept across sleep.
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         retain_q <= '0;
         tcfg_q <= 3'h0;
         tcmp_q <= 32'h0;
         imask_q <= '0;
      end else if (wr_w) begin
         if (i_paddr == ADDR_RETAIN) begin
            retain_q <= i_pwdata[NUM_BANKS-1:0];
         end
         if (i_paddr == ADDR_TCFG) begin
            tcfg_q <= i_pwdata[2:0];
         end
         if (i_paddr == ADDR_TCMP) begin
            tcmp_q <= i_pwdata;
         end
         if (i_paddr == ADDR_IMASK) begin
            imask_q <= i_pwdata[IRQ_W-1:0];
         end
      end
   end

   // Sticky status; a new event beats a write-one-to-clear in the same cycle.
   assign iset_w[IRQ_WAKE_BIT] = dsleep_ev_w || idle_exit_w;
   assign iset_w[IRQ_MATCH_BIT] = tmatch_w;
   assign iclr_w = (wr_w && i_paddr == ADDR_ISTAT) ? i_pwdata[IRQ_W-1:0] : '0;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         istat_q <= '0;
      end else begin
         istat_q <= (istat_q & ~iclr_w) | iset_w;
      end
   end
   assign o_irq = |(istat_q & imask_q);

   // Sleep timer in the always-on domain.
   prss_sleep_timer #(
      .CNT_W(32)
   ) u_timer (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_run(tmr_run_w),
      .i_src_slow(tcfg_q[TC_SRC_BIT]),
      .i_xtal_tick(i_xtal32k_tick),
      .i_rc_tick(i_rc10k_tick),
      .i_cmp(tcmp_q),
      .o_count(tcnt_w),
      .o_match(tmatch_w)
   );

   // Power and reset outputs decoded from the state and reset hold flops.
   assign o_cpu_halt = (state_q == ST_IDLE);
   assign o_aon_pwr_en = 1'b1;
   assign o_core_pwr_en = !true_ds_w;
   assign o_flash_pwr_en = !true_ds_w;
   assign o_ram_retain_ldo_en = true_ds_w;
   assign o_core_rst = (rst_cnt_q != 5'h0) || true_ds_w;
   assign o_periph_rst = o_core_rst || (state_q == ST_DS0);
   assign o_dbg_rst = (rst_cnt_q != 5'h0) && full_q;
   assign o_sysclk_sel_xtal = clksel_q;
   assign o_lf_clk_en = !clocks_off_w;

   // Each bank keeps its supply in DS1 and DS2 only when selected; DS0 keeps every bank powered.
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      assign o_ram_bank_retain[b] = true_ds_w && retain_q[b];
      assign o_ram_bank_pwr[b] = !true_ds_w || retain_q[b];
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   // A reset event in the entry cycle wins and keeps the device running.
   sequence s_ds_entry;
      sleep_go_w && !ext_ev_w && (mode_state_w == ST_DS1 || mode_state_w == ST_DS2);
   endsequence
   sequence s_ds_held;
      !o_core_pwr_en && !o_flash_pwr_en && o_core_rst;
   endsequence

   idle_power_a: assert property (state_q == ST_IDLE |-> o_core_pwr_en && !o_core_rst && o_cpu_halt)
      else $error("Idle sleep removed power or asserted reset.");
   idle_exit_a: assert property (idle_exit_w |=> state_q == ST_RUN && !o_cpu_halt)
      else $error("Interrupt did not end idle sleep.");
   ds_entry_a: assert property (s_ds_entry |=> s_ds_held)
      else $error("Deep sleep entry left core or flash powered.");
   ds1_timer_a: assert property (state_q == ST_DS1 && tcfg_q == 3'h1 |-> tmr_run_w && !o_core_pwr_en)
      else $error("Timer stopped in first deep sleep.");
   ds2_timer_a: assert property (state_q == ST_DS2 && !i_gpio_wake && !ext_ev_w |=> state_q == ST_DS2)
      else $error("Second deep sleep woke without a pin event.");
   ds0_reset_a: assert property (state_q == ST_DS0 |-> o_core_pwr_en && o_periph_rst && !o_dbg_rst)
      else $error("Emulated deep sleep reset the wrong parts.");
   retain_map_a: assert property (true_ds_w |-> o_ram_retain_ldo_en && o_ram_bank_retain == retain_q)
      else $error("Retained banks differ from the selection.");
   cause_rec_a: assert property (any_ev_w |=> cause_q == $past(ev_w) && rst_cnt_q == RST_HOLD_CYCLES)
      else $error("Reset cause not recorded.");
   wake_rc_a: assert property (dsleep_ev_w && true_ds_w |=> o_core_rst && !o_sysclk_sel_xtal ##1 !o_sysclk_sel_xtal)
      else $error("Core came up without the RC clock.");
   // The enable falls two cycles after expiry, one cycle after the core reset that the expiry raises.
   wdog_fire_a: assert property (wd_fire_w |=> cause_q[CS_WDOG] && o_core_rst ##1 !wd_en_q)
      else $error("Watchdog expiry gave no reset.");
   pin_only_a: assert property (clocks_off_w && !i_gpio_wake && !ext_ev_w |=> state_q == $past(state_q))
      else $error("Woke from lowest power without a pin event.");

   // A core reset must not let a sleep request through, and quiet cycles keep the cause record.
   sleep_refuse_a: assert property (o_core_rst && state_q == ST_RUN |=> state_q == ST_RUN)
      else $error("Sleep request taken during a core reset.");
   cause_hold_a: assert property (!any_ev_w |=> cause_q == $past(cause_q))
      else $error("Reset cause changed without a reset event.");
   wake_irq_a: assert property (dsleep_ev_w |=> istat_q[IRQ_WAKE_BIT] && state_q == ST_RUN)
      else $error("Deep sleep wake left no status or no running state.");
endmodule // prss_sequencer

// ### rtl/prss_pkg.sv
// Constants, register map and state encoding of the power, reset and sleep sequencer.
package prss_pkg;
   // Register byte offsets on the APB port.
   localparam logic [7:0] ADDR_SLEEP = 8'h00;
   localparam logic [7:0] ADDR_RETAIN = 8'h04;
   localparam logic [7:0] ADDR_CAUSE = 8'h08;
   localparam logic [7:0] ADDR_CLKSEL = 8'h0C;
   localparam logic [7:0] ADDR_WDOG = 8'h10;
   localparam logic [7:0] ADDR_TCFG = 8'h14;
   localparam logic [7:0] ADDR_TCMP = 8'h18;
   localparam logic [7:0] ADDR_TCNT = 8'h1C;
   localparam logic [7:0] ADDR_ISTAT = 8'h20;
   localparam logic [7:0] ADDR_IMASK = 8'h24;
   localparam logic [7:0] ADDR_SWRST = 8'h28;
   // Sleep mode request codes, written to the sleep register.
   localparam logic [2:0] MODE_IDLE = 3'h1;
   localparam logic [2:0] MODE_DS1 = 3'h2;
   localparam logic [2:0] MODE_DS2 = 3'h3;
   localparam logic [2:0] MODE_DS0 = 3'h4;
   // Field positions.
   localparam int WD_EN_BIT = 0;
   localparam int WD_KICK_BIT = 1;
   localparam int TC_EN_BIT = 0;
   localparam int TC_SRC_BIT = 1;
   localparam int TC_OFF_BIT = 2;
   localparam int IRQ_WAKE_BIT = 0;
   localparam int IRQ_MATCH_BIT = 1;
   localparam int IRQ_W = 2;
   // Software reset key; the value is arbitrary.
   localparam logic [31:0] SWRST_KEY = 32'h0000_00A5;
   // Reset cause flag positions.
   localparam int CS_HIGH_VOLTAGE_POWER_ON_RESET = 0;
   localparam int CS_LOW_VOLTAGE_POWER_ON_RESET = 1;
   localparam int CS_PIN = 2;
   localparam int CS_WDOG = 3;
   localparam int CS_SW = 4;
   localparam int CS_OPT = 5;
   localparam int CS_DBG = 6;
   localparam int CS_TEST = 7;
   localparam int CS_DSLEEP = 8;
   localparam int CAUSE_W = 9;
   // Sources that also reset the debug components.
   localparam logic [8:0] CAUSE_FULL_MASK = 9'h087;
   localparam logic [8:0] CAUSE_RST_VAL = 9'h001;
   localparam logic [4:0] RST_HOLD_CYCLES = 5'h10;
   // Clock rates and the slow tick divider.
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int RC10K_HZ = 10_000;
   localparam int SLOW_TICK_HZ = 1_000;
   localparam int SLOW_DIV = RC10K_HZ / SLOW_TICK_HZ;
   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_IDLE = 3'h1,
      ST_DS1 = 3'h2,
      ST_DS2 = 3'h3,
      ST_DS0 = 3'h4
   } prss_state_e;
endpackage

// ### rtl/prss_sleep_timer.sv
// Sleep timer counter with its clock source selection and slow tick divider.
module prss_sleep_timer import prss_pkg::*; #(
   parameter int CNT_W = 32
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic i_src_slow,
   input wire logic i_xtal_tick,
   input wire logic i_rc_tick,
   input wire logic [CNT_W-1:0] i_cmp,
   output logic [CNT_W-1:0] o_count,
   output logic o_match
);
   logic [3:0] div_q;
   logic [3:0] div_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic match_q;
   logic slow_tick_w;
   logic tick_w;

   // The slow tick fires on every tenth RC edge; the divider pauses with the timer.
   assign slow_tick_w = i_rc_tick && (div_q == 4'(SLOW_DIV - 1));
   assign div_d = !(i_run && i_rc_tick) ? div_q : (slow_tick_w ? 4'h0 : div_q + 4'h1);
   assign tick_w = i_run && (i_src_slow ? slow_tick_w : i_xtal_tick);
   assign cnt_d = tick_w ? cnt_q + 1'b1 : cnt_q;

   // Counter and match pulse; the count wraps silently at the top of its range.
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         div_q <= 4'h0;
         cnt_q <= '0;
         match_q <= 1'b0;
      end else begin
         div_q <= div_d;
         cnt_q <= cnt_d;
         match_q <= tick_w && (cnt_d == i_cmp);
      end
   end

   assign o_count = cnt_q;
   assign o_match = match_q;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   timer_stop_a: assert property (!i_run |=> cnt_q == $past(cnt_q))
      else $error("Sleep timer moved while stopped.");
   slow_div_a: assert property (i_run && i_src_slow && !slow_tick_w |=> cnt_q == $past(cnt_q))
      else $error("Slow tick source counted without a divided tick.");
endmodule // prss_sleep_timer

// ### verif/prss_core_model.sv
// Behavioural model of the processor side: interrupt source and slow oscillator ticks.
module prss_core_model #(
   parameter int IRQ_DELAY = 5,
   parameter int XTAL_DIV = 30,
   parameter int RC_DIV = 4
) (
   input wire logic i_sys_clk,
   input wire logic i_cpu_halt,
   output logic o_irq = 1'b0,
   output logic o_xtal32k_tick = 1'b0,
   output logic o_rc10k_tick = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int halt_cnt = 0;
   int xt_cnt = 0;
   int rc_cnt = 0;
   // An interrupt arrives some cycles into idle sleep and is withdrawn once the core runs.
   always @(posedge i_sys_clk) begin
      halt_cnt <= i_cpu_halt ? halt_cnt + 1 : 0;
      o_irq <= i_cpu_halt && halt_cnt >= IRQ_DELAY;
   end
   // Both oscillators run free, so their ticks keep coming during deep sleep too.
   always @(posedge i_sys_clk) begin
      xt_cnt <= (xt_cnt == XTAL_DIV - 1) ? 0 : xt_cnt + 1;
      rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
      o_xtal32k_tick <= xt_cnt == XTAL_DIV - 1;
      o_rc10k_tick <= rc_cnt == RC_DIV - 1;
   end
endmodule // prss_core_model

// ### verif/power_reset_sleep_sequencer_test.sv
// Self-checking testbench of the power, reset and sleep sequencer.
module power_reset_sleep_sequencer_test import prss_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, gpio = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, c;
   logic [5:0] src = 6'h00;
   logic [7:0] bank_pwr, bank_ret, ret;
   logic pready, pslverr, cpu_halt, aon, core_pwr, flash, ldo, core_rst, periph_rst, dbg_rst, sel_xtal, lf_en, irq_out;
   wire irq, xt, rc;
   int fails = 0;
   int cmp_count = 0;
   int cs_map [6];
   prss_sequencer #(.NUM_BANKS(8), .WDOG_CYCLES(32'd50)) u_dut (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_irq(irq), .i_gpio_wake(gpio), .i_xtal32k_tick(xt),
      .i_rc10k_tick(rc), .i_high_voltage_power_on_reset(src[0]), .i_low_voltage_power_on_reset(src[1]),
      .i_external_reset_pin_n(!src[2]), .i_option_byte_error(src[3]), .i_debug_reset_req(src[4]),
      .i_scan_port_test_reset(src[5]), .o_cpu_halt(cpu_halt), .o_aon_pwr_en(aon), .o_core_pwr_en(core_pwr),
      .o_flash_pwr_en(flash), .o_ram_retain_ldo_en(ldo), .o_ram_bank_pwr(bank_pwr), .o_ram_bank_retain(bank_ret),
      .o_core_rst(core_rst), .o_periph_rst(periph_rst), .o_dbg_rst(dbg_rst), .o_sysclk_sel_xtal(sel_xtal),
      .o_lf_clk_en(lf_en), .o_irq(irq_out));
   prss_core_model u_core (.i_sys_clk(clk), .i_cpu_halt(cpu_halt), .o_irq(irq), .o_xtal32k_tick(xt),
      .o_rc10k_tick(rc));
   // Free-running system clock.
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %08h expected %08h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // One APB transfer; the request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // Outputs are looked at on falling edges, once the state has moved.
   task automatic look();
      repeat (2) @(negedge clk);
   endtask
   // Waits, bounded, until the core runs again out of reset; a first pause lets a fresh reset show.
   task automatic settle();
      int n;
      n = 0;
      repeat (3) @(negedge clk);
      while ((core_rst !== 1'b0 || cpu_halt !== 1'b0) && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk(32'(n < 400), 32'h1);
   endtask
   task automatic pin_wake();
      @(posedge clk);
      gpio <= 1'b1;
      @(posedge clk);
      gpio <= 1'b0;
      settle();
   endtask
   function automatic logic [31:0] exp_bank(input logic ds, input logic [7:0] r);
      return ds ? 32'(r) : 32'h0000_00FF;
   endfunction
   function automatic logic [31:0] cause_bit(input int i);
      return 32'h1 << i;
   endfunction
   // Main sequence: reset, reset sources, every sleep mode, timer and watchdog.
   initial begin
      rd = $urandom(69377);
      cs_map = '{CS_HIGH_VOLTAGE_POWER_ON_RESET, CS_LOW_VOLTAGE_POWER_ON_RESET, CS_PIN, CS_OPT, CS_DBG, CS_TEST};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk(32'(core_rst & dbg_rst), 32'h1);
      chk(32'(aon), 32'h1);
      chk(32'(sel_xtal), 32'h0);
      settle();
      rdchk(ADDR_CAUSE, 32'(CAUSE_RST_VAL));
      rdchk(8'h2C, 32'h0);
      chk({30'h0, pready, err}, 32'h3);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         src <= 6'h01 << i;
         @(posedge clk);
         src <= 6'h00;
         @(negedge clk);
         chk(32'(dbg_rst), 32'(CAUSE_FULL_MASK[cs_map[i]]));
         settle();
         rdchk(ADDR_CAUSE, cause_bit(cs_map[i]));
      end
      apb(1'b1, ADDR_SWRST, 32'h0000_005A);
      look();
      chk(32'(core_rst), 32'h0);
      apb(1'b1, ADDR_SWRST, SWRST_KEY);
      apb(1'b1, ADDR_SLEEP, 32'(MODE_IDLE));
      rdchk(ADDR_SLEEP, 32'h0);
      settle();
      rdchk(ADDR_CAUSE, cause_bit(CS_SW));
      apb(1'b1, ADDR_SLEEP, 32'h0000_0007);
      rdchk(ADDR_SLEEP, 32'h0);
      apb(1'b1, ADDR_IMASK, 32'h3);
      apb(1'b1, ADDR_SLEEP, 32'(MODE_IDLE));
      look();
      chk({cpu_halt, core_pwr, flash, core_rst, periph_rst}, 32'h1C);
      settle();
      rdchk(ADDR_ISTAT, 32'h1);
      chk(32'(irq_out), 32'h1);
      apb(1'b1, ADDR_ISTAT, 32'h1);
      look();
      chk(32'(irq_out), 32'h0);
      apb(1'b1, ADDR_CLKSEL, 32'h1);
      look();
      chk(32'(sel_xtal), 32'h1);
      ret = 8'($urandom);
      apb(1'b1, ADDR_RETAIN, 32'(ret));
      apb(1'b1, ADDR_TCFG, 32'h1);
      rdchk(ADDR_TCFG, 32'h1);
      apb(1'b0, ADDR_TCNT, 32'h0);
      apb(1'b1, ADDR_TCMP, rd + $urandom_range(3, 5));
      apb(1'b1, ADDR_SLEEP, 32'(MODE_DS1));
      look();
      chk({core_pwr, flash, ldo, core_rst, lf_en}, 32'h7);
      chk(32'(bank_pwr), exp_bank(1'b1, ret));
      chk(32'(bank_ret), 32'(ret));
      settle();
      rdchk(ADDR_CAUSE, cause_bit(CS_DSLEEP));
      chk(32'(sel_xtal), 32'h0);
      chk(32'(bank_pwr), exp_bank(1'b0, ret));
      rdchk(ADDR_ISTAT, 32'h3);
      apb(1'b1, ADDR_ISTAT, 32'h3);
      apb(1'b0, ADDR_TCNT, 32'h0);
      apb(1'b1, ADDR_TCMP, rd + 32'h2);
      apb(1'b1, ADDR_SLEEP, 32'(MODE_DS2));
      repeat (300) @(posedge clk);
      look();
      chk(32'(core_pwr), 32'h0);
      pin_wake();
      rdchk(ADDR_CAUSE, cause_bit(CS_DSLEEP));
      apb(1'b1, ADDR_SLEEP, 32'(MODE_DS0));
      look();
      chk({core_pwr, periph_rst, dbg_rst, flash}, 32'hD);
      pin_wake();
      apb(1'b1, ADDR_TCFG, 32'h5);
      apb(1'b1, ADDR_SLEEP, 32'(MODE_DS1));
      repeat (300) @(posedge clk);
      look();
      chk({core_pwr, lf_en}, 32'h0);
      pin_wake();
      apb(1'b1, ADDR_TCFG, 32'h3);
      apb(1'b0, ADDR_TCNT, 32'h0);
      c = rd;
      repeat (400) @(posedge clk);
      apb(1'b0, ADDR_TCNT, 32'h0);
      chk(32'((rd - c) inside {[32'd9 : 32'd11]}), 32'h1);
      rdchk(ADDR_CAUSE, cause_bit(CS_DSLEEP));
      apb(1'b1, ADDR_WDOG, 32'h1);
      repeat (6) begin
         repeat (20) @(posedge clk);
         apb(1'b1, ADDR_WDOG, 32'h3);
      end
      rdchk(ADDR_CAUSE, cause_bit(CS_DSLEEP));
      repeat (60) @(posedge clk);
      settle();
      rdchk(ADDR_CAUSE, cause_bit(CS_WDOG));
      conclude();
   end
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      conclude();
   end
endmodule // power_reset_sleep_sequencer_test
